// ===== src/rpso_pkg.sv
package rpso_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned HOLD_TIME_US    = 5600;
  localparam int unsigned HOLD_CYCLES     = (HOLD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REF_CLK_HZ      = 6_000_000;
  localparam int unsigned HOLD_CNT_W      = 16;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RST_OUT_N_RESET  = 1'h0;
  localparam logic PWR_EN_N_RESET   = 1'h1;
  localparam logic EE_OE_N_RESET    = 1'h1;
  localparam logic SYNC_RESET       = 1'h0;
  localparam logic PIN_N_SYNC_RESET = 1'h1;
  localparam logic PIN_DRIVE_RESET  = 1'h0;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    RPSO_HOLD    = 2'b00,
    RPSO_RUN     = 2'b01,
    RPSO_EXT_RST = 2'b10
  } rpso_state_type;

endpackage

// ===== src/rpso_sync_if.sv
`timescale 1ns/1ps
`default_nettype none

interface rpso_sync_if;
  logic ext_reset_n_raw;
  logic suspend_raw;
  logic configured_raw;
  logic ext_reset_n;
  logic suspend;
  logic configured;

  modport sync (
    input  ext_reset_n_raw,
    input  suspend_raw,
    input  configured_raw,
    output ext_reset_n,
    output suspend,
    output configured
  );
  modport user (
    input ext_reset_n,
    input suspend,
    input configured
  );
endinterface

`default_nettype wire

// ===== src/rpso_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rpso_sync (
  input  wire logic    core_clk,
  input  wire logic    rst,
  input  wire logic    clk_en,
  rpso_sync_if.sync    sif
);

  // ----------------------------------------
  // Two-stage pin synchronisers
  // ----------------------------------------
  logic [2:0] stage1_ff;
  logic [2:0] stage2_ff;
  logic [2:0] raw_bits;
  logic [2:0] rst_vals;

  assign raw_bits = {sif.configured_raw, sif.suspend_raw, sif.ext_reset_n_raw};
  // External reset idles high so it must not glitch low out of reset
  assign rst_vals = {rpso_pkg::SYNC_RESET, rpso_pkg::SYNC_RESET, rpso_pkg::PIN_N_SYNC_RESET};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (rst) begin
          stage1_ff[gi] <= rst_vals[gi];
          stage2_ff[gi] <= rst_vals[gi];
        end else if (clk_en) begin
          stage1_ff[gi] <= raw_bits[gi];
          stage2_ff[gi] <= stage1_ff[gi];
        end
      end
    end
  endgenerate

  assign sif.ext_reset_n = stage2_ff[0];
  assign sif.suspend     = stage2_ff[1];
  assign sif.configured  = stage2_ff[2];

endmodule

`default_nettype wire

// ===== src/rpso_top.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Reset output low 5.6 ms after power-up
// - External reset low forces reset output low
// - USB bus reset never touches reset output
// - EEPROM pins tri-stated in reset, clock driven after
// - Power enable low once configured and out of reset, high in suspend
// - Oscillator output stops during USB suspend
// - Reference clock is 6 MHz crystal or external
module rpso_top #(
  parameter int unsigned HOLD_CYCLES = rpso_pkg::HOLD_CYCLES,
  parameter int unsigned CNT_W       = rpso_pkg::HOLD_CNT_W
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic ext_reset_n,
  input  wire logic usb_bus_reset,
  input  wire logic usb_configured,
  input  wire logic usb_suspend,
  input  wire logic osc_in,
  input  wire logic ee_select_in,
  input  wire logic ee_clock_in,
  input  wire logic ee_data_in,
  input  wire logic ee_data_oe_req,
  output logic      reset_out_n,
  output logic      power_enable_n,
  output logic      osc_out,
  output logic      eeprom_select,
  output logic      eeprom_select_oe_n,
  output logic      eeprom_serial_clock,
  output logic      eeprom_serial_clock_oe_n,
  output logic      eeprom_data_io_out,
  output logic      eeprom_data_io_oe_n
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Counter must reach HOLD_CYCLES-1 without wrapping
  if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (64'h1 << CNT_W)) begin : g_bad_hold
    $error("hold count does not fit counter");
  end

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  rpso_sync_if sif ();

  assign sif.ext_reset_n_raw = ext_reset_n;
  assign sif.suspend_raw     = usb_suspend;
  assign sif.configured_raw  = usb_configured;

  rpso_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .sif      (sif.sync)
  );

  // Bus reset deliberately has no load: it must not reach reset_out_n
  logic unused_bus_reset;
  assign unused_bus_reset = usb_bus_reset;

  // ----------------------------------------
  // Reset sequencer
  // ----------------------------------------
  rpso_pkg::rpso_state_type state_ff;
  rpso_pkg::rpso_state_type nxt_state;
  logic [CNT_W-1:0]         cnt_ff;
  logic [CNT_W-1:0]         nxt_cnt;
  logic                     hold_done;
  logic                     ext_low;

  assign ext_low   = !sif.ext_reset_n;
  assign hold_done = (cnt_ff == CNT_W'(HOLD_CYCLES - 1));

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      rpso_pkg::RPSO_HOLD: begin
        if (ext_low) begin
          nxt_state = rpso_pkg::RPSO_EXT_RST;
          nxt_cnt   = '0;
        end else if (hold_done) begin
          nxt_state = rpso_pkg::RPSO_RUN;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
      end
      rpso_pkg::RPSO_RUN: begin
        if (ext_low) begin
          nxt_state = rpso_pkg::RPSO_EXT_RST;
        end
      end
      rpso_pkg::RPSO_EXT_RST: begin
        nxt_cnt = '0;
        if (!ext_low) begin
          nxt_state = rpso_pkg::RPSO_HOLD;
        end
      end
      default: begin
        nxt_state = rpso_pkg::RPSO_HOLD;
        nxt_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= rpso_pkg::RPSO_HOLD;
      cnt_ff   <= '0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  logic in_reset_nxt;
  logic nxt_pwr_en_n;
  logic osc_s1_ff;
  logic osc_s2_ff;

  assign in_reset_nxt = (nxt_state != rpso_pkg::RPSO_RUN);
  // Stays enabled only while configured and not suspended
  assign nxt_pwr_en_n = in_reset_nxt || !sif.configured || sif.suspend;

  // Oscillator sampled onto core clock; a real cell would gate the analog output
  always_ff @(posedge core_clk) begin
    if (rst) begin
      osc_s1_ff <= rpso_pkg::SYNC_RESET;
      osc_s2_ff <= rpso_pkg::SYNC_RESET;
    end else if (clk_en) begin
      osc_s1_ff <= osc_in;
      osc_s2_ff <= osc_s1_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reset_out_n              <= rpso_pkg::RST_OUT_N_RESET;
      power_enable_n           <= rpso_pkg::PWR_EN_N_RESET;
      osc_out                  <= rpso_pkg::PIN_DRIVE_RESET;
      eeprom_select_oe_n       <= rpso_pkg::EE_OE_N_RESET;
      eeprom_serial_clock_oe_n <= rpso_pkg::EE_OE_N_RESET;
      eeprom_data_io_oe_n      <= rpso_pkg::EE_OE_N_RESET;
      eeprom_select            <= rpso_pkg::PIN_DRIVE_RESET;
      eeprom_serial_clock      <= rpso_pkg::PIN_DRIVE_RESET;
      eeprom_data_io_out       <= rpso_pkg::PIN_DRIVE_RESET;
    end else if (clk_en) begin
      reset_out_n              <= !in_reset_nxt;
      power_enable_n           <= nxt_pwr_en_n;
      osc_out                  <= sif.suspend ? osc_out : osc_s2_ff;
      eeprom_select_oe_n       <= in_reset_nxt;
      eeprom_serial_clock_oe_n <= in_reset_nxt;
      eeprom_data_io_oe_n      <= in_reset_nxt || !ee_data_oe_req;
      eeprom_select            <= ee_select_in;
      eeprom_serial_clock      <= ee_clock_in;
      eeprom_data_io_out       <= ee_data_in;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence ext_low_seen;
    !sif.ext_reset_n;
  endsequence

  sequence ext_released;
    $rose(sif.ext_reset_n);
  endsequence

  ext_forces_rst_a: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
    ext_low_seen |=> !reset_out_n)
    else $error("reset output high while external reset low");

  hold_restart_a: assert property (@(posedge core_clk) disable iff (rst)
    (ext_released ##0 clk_en) |=> !reset_out_n)
    else $error("reset output released without hold interval");

  hold_length_a: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
    $rose(reset_out_n) |-> (cnt_ff == CNT_W'(HOLD_CYCLES - 1)))
    else $error("reset output released at wrong count");

  ee_tristate_a: assert property (@(posedge core_clk) disable iff (rst)
    !reset_out_n |-> (eeprom_select_oe_n && eeprom_serial_clock_oe_n && eeprom_data_io_oe_n))
    else $error("eeprom pin driven during reset");

  ee_clock_drv_a: assert property (@(posedge core_clk) disable iff (rst)
    reset_out_n |-> !eeprom_serial_clock_oe_n)
    else $error("eeprom clock not driven outside reset");

  pwr_suspend_a: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
    sif.suspend |=> power_enable_n)
    else $error("power enable active during suspend");

  pwr_config_a: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
    (sif.configured && !sif.suspend && reset_out_n && sif.ext_reset_n) |=> !power_enable_n)
    else $error("power enable not asserted when configured");

  osc_stop_a: assert property (@(posedge core_clk) disable iff (rst)
    (sif.suspend && $past(sif.suspend)) |=> $stable(osc_out))
    else $error("oscillator output toggles in suspend");

  bus_reset_a: assert property (@(posedge core_clk) disable iff (rst || !clk_en)
    (usb_bus_reset && sif.ext_reset_n && reset_out_n) |=> reset_out_n)
    else $error("bus reset disturbed reset output");

endmodule

`default_nettype wire

// ===== tb/rpso_partner.sv
`timescale 1ns/1ps
`default_nettype none

module rpso_partner (
  input  wire logic rst_req,
  input  wire logic ee_cs,
  input  wire logic ee_cs_oe_n,
  input  wire logic ee_sk,
  input  wire logic ee_sk_oe_n,
  input  wire logic pwr_en_n,
  output logic      ext_reset_n,
  output logic      ext_power_on,
  output logic      ee_cs_pin,
  output logic      ee_sk_pin,
  output var logic  osc_in
);
  // ----------------------------------------
  // Far side
  // ----------------------------------------
  assign ext_reset_n = !rst_req;
  // Switched downstream supply; its interface pins lean on the pull-down option
  assign ext_power_on = !pwr_en_n;
  // No test-mode pin on this block: the far side keeps it low
  // Released pins float to the pull-up, not the last value
  assign ee_cs_pin = ee_cs_oe_n ? 1'h1 : ee_cs;
  assign ee_sk_pin = ee_sk_oe_n ? 1'h1 : ee_sk;
  initial begin
    osc_in = 1'h0;
    forever #83.333 osc_in = !osc_in;
  end
endmodule

`default_nettype wire

// ===== tb/reset_and_power_state_outputs_test.sv
`timescale 1ns/1ps
`default_nettype none

module reset_and_power_state_outputs_test;
  localparam int unsigned HOLD = 20;
  logic core_clk, rst, ext_req, bus_rst, cfg, susp, ee_clk;
  logic ext_n, osc_in, rst_out_n, pwr_n, osc_out, cs, cs_oe_n, sk, sk_oe_n;
  logic dat, dat_oe_n, cs_pin, sk_pin, seen;
  logic clk_en, ee_sel, ee_dat, ee_oe, ext_pwr;
  int   fail_count, comparisons, i;

  rpso_top #(.HOLD_CYCLES(HOLD)) i_rpso_top (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .ext_reset_n(ext_n),
    .usb_bus_reset(bus_rst), .usb_configured(cfg), .usb_suspend(susp),
    .osc_in(osc_in), .ee_select_in(ee_sel), .ee_clock_in(ee_clk),
    .ee_data_in(ee_dat), .ee_data_oe_req(ee_oe), .reset_out_n(rst_out_n),
    .power_enable_n(pwr_n), .osc_out(osc_out), .eeprom_select(cs),
    .eeprom_select_oe_n(cs_oe_n), .eeprom_serial_clock(sk),
    .eeprom_serial_clock_oe_n(sk_oe_n), .eeprom_data_io_out(dat),
    .eeprom_data_io_oe_n(dat_oe_n));

  rpso_partner i_rpso_partner (
    .rst_req(ext_req), .ee_cs(cs), .ee_cs_oe_n(cs_oe_n), .ee_sk(sk),
    .ee_sk_oe_n(sk_oe_n), .ext_reset_n(ext_n), .ee_cs_pin(cs_pin),
    .ee_sk_pin(sk_pin), .osc_in(osc_in), .pwr_en_n(pwr_n), .ext_power_on(ext_pwr));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string name, input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask

  // Bounded wait on reset_out_n (k=0) or power_enable_n (k=1)
  task automatic wait_for(input int k, input logic v, input int bound);
    int n;
    n = 0;
    while ((k == 0 ? rst_out_n : pwr_n) !== v && n < bound) begin
      tick(1);
      n++;
    end
    check(k == 0 ? "reset_out_n" : "power_enable_n", k == 0 ? rst_out_n : pwr_n, v);
    if ((k == 0 ? rst_out_n : pwr_n) !== v)
      finish_test();
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power_up();
    tick(HOLD - 1);
    check("reset_out_n", rst_out_n, 1'h0);
    check("sk_oe_n", sk_oe_n, 1'h1);
    check("data_oe_n", dat_oe_n, 1'h1);
    check("cs_pin", cs_pin, 1'h1);
    wait_for(0, 1'h1, 8);
    check("sk_oe_n", sk_oe_n, 1'h0);
    tick(3);
    check("sk_pin", sk_pin, 1'h0);
    check("power_enable_n", pwr_n, 1'h1);
    check("cs_pin", cs_pin, 1'h0);
    check("data_oe_n", dat_oe_n, 1'h0);
    check("data_out", dat, 1'h0);
    ee_oe = 1'h0;
    ee_dat = 1'h1;
    tick(1);
    check("data_oe_n", dat_oe_n, 1'h1);
    check("data_out", dat, 1'h1);
    $display("done power_up");
  endtask

  task automatic t_ext_reset();
    cfg = 1'h1;
    tick(6);
    ext_req = 1'h1;
    wait_for(0, 1'h0, 4);
    check("sk_oe_n", sk_oe_n, 1'h1);
    tick(6);
    check("reset_out_n", rst_out_n, 1'h0);
    check("power_enable_n", pwr_n, 1'h1);
    ext_req = 1'h0;
    tick(HOLD);
    check("reset_out_n", rst_out_n, 1'h0);
    wait_for(0, 1'h1, 8);
    $display("done ext_reset");
  endtask

  task automatic t_bus_reset();
    bus_rst = 1'h1;
    for (i = 0; i < 10; i++) begin
      tick(1);
      check("reset_out_n", rst_out_n, 1'h1);
    end
    bus_rst = 1'h0;
    $display("done bus_reset");
  endtask

  task automatic t_suspend();
    int moves;
    wait_for(1, 1'h0, 8);
    check("ext_power", ext_pwr, 1'h1);
    moves = 0;
    seen = osc_out;
    for (i = 0; i < 20; i++) begin
      tick(1);
      moves += (osc_out !== seen);
      seen = osc_out;
    end
    check("osc_running", moves > 0, 1'h1);
    susp = 1'h1;
    wait_for(1, 1'h1, 6);
    check("ext_power", ext_pwr, 1'h0);
    tick(2);
    seen = osc_out;
    for (i = 0; i < 20; i++) begin
      tick(1);
      check("osc_out", osc_out, seen);
    end
    susp = 1'h0;
    wait_for(1, 1'h0, 6);
    $display("done suspend");
  endtask

  // Clock enable low: pin changes must not leak into any state
  task automatic t_freeze();
    clk_en = 1'h0;
    ext_req = 1'h1;
    susp = 1'h1;
    for (i = 0; i < 8; i++) begin
      tick(1);
      check("reset_out_n", rst_out_n, 1'h1);
      check("power_enable_n", pwr_n, 1'h0);
    end
    ext_req = 1'h0;
    susp = 1'h0;
    tick(1);
    clk_en = 1'h1;
    tick(4);
    check("reset_out_n", rst_out_n, 1'h1);
    check("power_enable_n", pwr_n, 1'h0);
    $display("done freeze");
  endtask

  task automatic t_mid_reset();
    rst = 1'h1;
    tick(2);
    rst = 1'h0;
    check("reset_out_n", rst_out_n, 1'h0);
    check("power_enable_n", pwr_n, 1'h1);
    check("sk_oe_n", sk_oe_n, 1'h1);
    tick(HOLD - 1);
    check("reset_out_n", rst_out_n, 1'h0);
    wait_for(0, 1'h1, 1);
    $display("done mid_reset");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = !core_clk;
  end

  initial begin
    rst = 1'h1;
    ext_req = 1'h0;
    bus_rst = 1'h0;
    cfg = 1'h0;
    susp = 1'h0;
    ee_clk = 1'h0;
    clk_en = 1'h1;
    ee_sel = 1'h0;
    ee_dat = 1'h0;
    ee_oe = 1'h1;
    fail_count = 0;
    comparisons = 0;
    tick(12);
    rst = 1'h0;
    t_power_up();
    t_ext_reset();
    t_bus_reset();
    t_suspend();
    t_freeze();
    t_mid_reset();
    finish_test();
  end
endmodule

`default_nettype wire
